// ==== design/tss_consts.svh ====
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

// ==========================================================
// Register word offsets
`define TSS_ADDR_W          5
`define TSS_OFF_CONTROL     5'h00
`define TSS_OFF_STEP_DELAY  5'h01
`define TSS_OFF_TIMER0_LIM  5'h02
`define TSS_OFF_TIMER1_LIM  5'h03
`define TSS_OFF_LOOP0_LIM   5'h04
`define TSS_OFF_LOOP1_LIM   5'h05
`define TSS_OFF_HOLD        5'h06
`define TSS_OFF_ADJUST      5'h07
`define TSS_OFF_LITERAL     5'h08
`define TSS_OFF_POINTER     5'h09
`define TSS_OFF_BROADCAST   5'h0a
`define TSS_OFF_ADC_SELECT  5'h0b
`define TSS_OFF_LOOP0_CNT   5'h0c
`define TSS_OFF_LOOP1_CNT   5'h0d
`define TSS_QUEUE_BASE_BIT  4

// ==========================================================
// Control register fields
`define TSS_CTL_ENABLE      0
`define TSS_CTL_START       1
`define TSS_CTL_SWTRIG      2
`define TSS_CTL_DELAY_ON    3
`define TSS_CTL_BUSY        4

// ==========================================================
// Reset values
`define TSS_RST_WORD        16'h0000
`define TSS_RST_PTR         5'h00
`define TSS_RST_DELAY_ON    1'b1

// ==========================================================
// Opcodes (upper nibble of a step byte)
`define TSS_OP_CONTROL      4'h0
`define TSS_OP_ADDCOPY      4'h1
`define TSS_OP_WAIT_RISE    4'h4
`define TSS_OP_WAIT_FALL    4'h5
`define TSS_OP_IRQ          4'h7
`define TSS_OP3_STROBE      3'h1
`define TSS_OP3_TRIGGER     3'h4
`define TSS_OP3_JUMP        3'h5
`define TSS_OP3_LOOP0       3'h6
`define TSS_OP3_LOOP1       3'h7

// ==========================================================
// Control options
`define TSS_OPT_DELAY_OFF   4'h2
`define TSS_OPT_DELAY_ON    4'h6
`define TSS_OPT_TIMER0      4'h8
`define TSS_OPT_TIMER1      4'h9
`define TSS_OPT_SWTRIG      4'hb
`define TSS_OPT_ADC_LOOP0   4'hc
`define TSS_OPT_ADC_LOOP1   4'hd
`define TSS_OPT_ADC_LIT     4'he
`define TSS_OPT_BROADCAST   4'hf
`define TSS_TGT_LAST        3'h5

`endif

// ==== design/tss_pkg.sv ====
package tss_pkg;

   typedef enum logic [2:0] {
      TSS_IDLE  = 3'b000,
      TSS_FETCH = 3'b001,
      TSS_EXEC  = 3'b010,
      TSS_WAIT  = 3'b011,
      TSS_DELAY = 3'b100,
      TSS_NEXT  = 3'b101
   } tss_state_e;

   typedef enum logic [2:0] {
      TSS_W_RISE   = 3'b000,
      TSS_W_FALL   = 3'b001,
      TSS_W_TIMER0 = 3'b010,
      TSS_W_TIMER1 = 3'b011,
      TSS_W_SWTRIG = 3'b100
   } tss_wait_e;

   typedef logic [15:0] tss_word_t;

endpackage

// ==== design/tss_input_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module tss_input_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] risePulse,
   output logic      [WIDTH-1:0] fallPulse
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] level;
   wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

   // stage1 feeds only stage2; a change counts once stage2 and stage3 agree
   always_ff @(posedge core_clk) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         level     <= '0;
         risePulse <= '0;
         fallPulse <= '0;
      end else begin
         level     <= next_level;
         risePulse <= next_level & ~level;
         fallPulse <= ~next_level & level;
      end
   end

endmodule

`default_nettype wire

// ==== design/tss_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.svh"

module tss_sequencer
   import tss_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic [`TSS_ADDR_W-1:0] regAddr,
   input  wire logic [15:0]            regWrData,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output logic      [15:0]            regRdData,
   input  wire logic [15:0]            triggerIn,
   output logic      [31:0]            triggerOut,
   output logic      [15:0]            irqOut,
   output logic      [15:0]            adcChannelSelect
);

   // ==========================================================
   // State
   tss_state_e  state;
   tss_wait_e   waitKind;
   logic        moduleEnable;
   logic        sequenceStart;
   logic        swTrigger;
   logic        swTriggerPrev;
   logic        delayOn;
   tss_word_t   stepDelayLimit;
   tss_word_t   timer0Limit;
   tss_word_t   timer1Limit;
   tss_word_t   loop0Limit;
   tss_word_t   loop1Limit;
   tss_word_t   holdValue;
   tss_word_t   adjustValue;
   tss_word_t   literalValue;
   tss_word_t   broadcastEnable;
   tss_word_t   loop0Count;
   tss_word_t   loop1Count;
   tss_word_t   timerCount;
   tss_word_t   delayCount;
   logic [4:0]  stepPointer;
   logic [4:0]  jumpTarget;
   logic        jumpTaken;
   logic [7:0]  stepByte;
   logic [3:0]  waitSelect;
   tss_word_t   stepQueue [8];
   logic [15:0] inRise;
   logic [15:0] inFall;

   tss_input_sync #(.WIDTH(16)) inputSync (
      .core_clk  (core_clk),
      .reset     (reset),
      .pinIn     (triggerIn),
      .risePulse (inRise),
      .fallPulse (inFall)
   );

   // ==========================================================
   // Decode
   wire       running   = moduleEnable & sequenceStart;
   wire       wrOpen    = regWrite & ~running;
   wire [3:0] opcode    = stepByte[7:4];
   wire [3:0] option    = stepByte[3:0];
   wire [4:0] fiveBit   = {opcode[0], option};
   wire       inExec    = (state == TSS_EXEC);
   wire       isControl = inExec & (opcode == `TSS_OP_CONTROL);
   wire       isAddCopy = inExec & (opcode == `TSS_OP_ADDCOPY);
   wire       isStrobe  = inExec & (opcode[3:1] == `TSS_OP3_STROBE);
   wire       isIrq     = inExec & (opcode == `TSS_OP_IRQ);
   wire       isTrigger = inExec & (opcode[3:1] == `TSS_OP3_TRIGGER);
   wire       isJump    = inExec & (opcode[3:1] == `TSS_OP3_JUMP);
   wire       isLoop0   = inExec & (opcode[3:1] == `TSS_OP3_LOOP0);
   wire       isLoop1   = inExec & (opcode[3:1] == `TSS_OP3_LOOP1);
   wire       loop0Done = (loop0Count == loop0Limit);
   wire       loop1Done = (loop1Count == loop1Limit);

   // Add/copy target: option[3] picks copy, option[2:0] the target
   wire [2:0] tgtIndex  = option[2:0];
   wire       tgtWrite  = isAddCopy & (tgtIndex <= `TSS_TGT_LAST);
   wire [5:0] tgtHit    = tgtWrite ? 6'h01 << tgtIndex : 6'h00;
   tss_word_t tgtCurrent;
   always_comb begin
      case (tgtIndex)
         3'h0:    tgtCurrent = loop0Limit;
         3'h1:    tgtCurrent = loop1Limit;
         3'h2:    tgtCurrent = timer0Limit;
         3'h3:    tgtCurrent = timer1Limit;
         3'h4:    tgtCurrent = stepDelayLimit;
         default: tgtCurrent = literalValue;
      endcase
   end
   wire tss_word_t tgtNew = option[3] ? holdValue
                                      : tgtCurrent + adjustValue;

   // Software write strobes per register
   wire wrStepDelay = wrOpen & (regAddr == `TSS_OFF_STEP_DELAY);
   wire wrTimer0    = wrOpen & (regAddr == `TSS_OFF_TIMER0_LIM);
   wire wrTimer1    = wrOpen & (regAddr == `TSS_OFF_TIMER1_LIM);
   wire wrLoop0     = wrOpen & (regAddr == `TSS_OFF_LOOP0_LIM);
   wire wrLoop1     = wrOpen & (regAddr == `TSS_OFF_LOOP1_LIM);
   wire wrHold      = wrOpen & (regAddr == `TSS_OFF_HOLD);
   wire wrAdjust    = wrOpen & (regAddr == `TSS_OFF_ADJUST);
   wire wrLiteral   = wrOpen & (regAddr == `TSS_OFF_LITERAL);
   wire wrPointer   = wrOpen & (regAddr == `TSS_OFF_POINTER);
   wire wrBroadcast = wrOpen & (regAddr == `TSS_OFF_BROADCAST);
   wire wrQueue     = wrOpen & regAddr[`TSS_QUEUE_BASE_BIT];
   // Control stays writable so software can always stop the sequence
   wire wrControl   = regWrite & (regAddr == `TSS_OFF_CONTROL);

   // Wait completion
   wire swTrigRise  = swTrigger & ~swTriggerPrev;
   logic waitMet;
   always_comb begin
      case (waitKind)
         TSS_W_RISE:   waitMet = inRise[waitSelect];
         TSS_W_FALL:   waitMet = inFall[waitSelect];
         TSS_W_TIMER0: waitMet = (timerCount == timer0Limit);
         TSS_W_TIMER1: waitMet = (timerCount == timer1Limit);
         TSS_W_SWTRIG: waitMet = swTrigRise;
         default:      waitMet = 1'b1;
      endcase
   end
   wire waitsNow = (isControl & ((option == `TSS_OPT_TIMER0) | (option == `TSS_OPT_TIMER1) |
                                 (option == `TSS_OPT_SWTRIG)))
                 | (inExec & ((opcode == `TSS_OP_WAIT_RISE) | (opcode == `TSS_OP_WAIT_FALL)));
   wire delayDone = ~delayOn | (delayCount == stepDelayLimit);

   // Read mux
   tss_word_t readMux;
   always_comb begin
      case (regAddr)
         `TSS_OFF_CONTROL:    readMux = {11'h000, (state != TSS_IDLE), delayOn,
                                         swTrigger, sequenceStart, moduleEnable};
         `TSS_OFF_STEP_DELAY: readMux = stepDelayLimit;
         `TSS_OFF_TIMER0_LIM: readMux = timer0Limit;
         `TSS_OFF_TIMER1_LIM: readMux = timer1Limit;
         `TSS_OFF_LOOP0_LIM:  readMux = loop0Limit;
         `TSS_OFF_LOOP1_LIM:  readMux = loop1Limit;
         `TSS_OFF_HOLD:       readMux = holdValue;
         `TSS_OFF_ADJUST:     readMux = adjustValue;
         `TSS_OFF_LITERAL:    readMux = literalValue;
         `TSS_OFF_POINTER:    readMux = {11'h000, stepPointer};
         `TSS_OFF_BROADCAST:  readMux = broadcastEnable;
         `TSS_OFF_ADC_SELECT: readMux = adcChannelSelect;
         `TSS_OFF_LOOP0_CNT:  readMux = loop0Count;
         `TSS_OFF_LOOP1_CNT:  readMux = loop1Count;
         default:             readMux = regAddr[`TSS_QUEUE_BASE_BIT] ? stepQueue[regAddr[2:0]]
                                                                     : `TSS_RST_WORD;
      endcase
   end

   // ==========================================================
   // Bus read port
   always_ff @(posedge core_clk) begin
      if (reset) regRdData <= `TSS_RST_WORD;
      else       regRdData <= regRead ? readMux : `TSS_RST_WORD;
   end

   // ==========================================================
   // Queue storage: no reset on purpose, contents outlive any reset
   always_ff @(posedge core_clk) begin
      if (wrQueue) stepQueue[regAddr[2:0]] <= regWrData;
   end

   // ==========================================================
   // Control register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         moduleEnable  <= 1'b0;
         sequenceStart <= 1'b0;
         swTrigger     <= 1'b0;
         swTriggerPrev <= 1'b0;
      end else begin
         swTriggerPrev <= swTrigger;
         if (wrControl) begin
            moduleEnable  <= regWrData[`TSS_CTL_ENABLE];
            sequenceStart <= regWrData[`TSS_CTL_START];
            swTrigger     <= regWrData[`TSS_CTL_SWTRIG];
         end
      end
   end

   // ==========================================================
   // Software-written data registers; no step writes them, and writes are blocked while running
   always_ff @(posedge core_clk) begin
      if (reset) begin
         holdValue       <= `TSS_RST_WORD;
         adjustValue     <= `TSS_RST_WORD;
         broadcastEnable <= `TSS_RST_WORD;
      end else begin
         if (wrHold)      holdValue       <= regWrData;
         if (wrAdjust)    adjustValue     <= regWrData;
         if (wrBroadcast) broadcastEnable <= regWrData;
      end
   end

   // Writes are blocked while running; if a step and a write meet in one cycle, the step wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         loop0Limit     <= `TSS_RST_WORD;
         loop1Limit     <= `TSS_RST_WORD;
         timer0Limit    <= `TSS_RST_WORD;
         timer1Limit    <= `TSS_RST_WORD;
         stepDelayLimit <= `TSS_RST_WORD;
         literalValue   <= `TSS_RST_WORD;
      end else begin
         if (tgtHit[0] | wrLoop0)     loop0Limit     <= tgtHit[0] ? tgtNew : regWrData;
         if (tgtHit[1] | wrLoop1)     loop1Limit     <= tgtHit[1] ? tgtNew : regWrData;
         if (tgtHit[2] | wrTimer0)    timer0Limit    <= tgtHit[2] ? tgtNew : regWrData;
         if (tgtHit[3] | wrTimer1)    timer1Limit    <= tgtHit[3] ? tgtNew : regWrData;
         if (tgtHit[4] | wrStepDelay) stepDelayLimit <= tgtHit[4] ? tgtNew : regWrData;
         if (tgtHit[5] | wrLiteral)   literalValue   <= tgtHit[5] ? tgtNew : regWrData;
      end
   end

   // ==========================================================
   // Step outputs: one-cycle pulses, channel select is a level
   always_ff @(posedge core_clk) begin
      if (reset) begin
         triggerOut       <= 32'h0000_0000;
         irqOut           <= 16'h0000;
         adcChannelSelect <= `TSS_RST_WORD;
      end else begin
         triggerOut <= isTrigger ? 32'h0000_0001 << fiveBit : 32'h0000_0000;
         irqOut     <= isIrq ? 16'h0001 << option : 16'h0000;
         if (isControl & (option == `TSS_OPT_BROADCAST))
            triggerOut <= {16'h0000, broadcastEnable};
         if (isStrobe)
            adcChannelSelect <= {adcChannelSelect[15:5], fiveBit};
         else if (isControl & (option == `TSS_OPT_ADC_LIT))
            adcChannelSelect <= literalValue;
         else if (isControl & (option == `TSS_OPT_ADC_LOOP0))
            adcChannelSelect <= loop0Count;
         else if (isControl & (option == `TSS_OPT_ADC_LOOP1))
            adcChannelSelect <= loop1Count;
      end
   end

   // ==========================================================
   // Loop counters
   always_ff @(posedge core_clk) begin
      if (reset | ~running) begin
         loop0Count <= `TSS_RST_WORD;
         loop1Count <= `TSS_RST_WORD;
      end else begin
         // Cleared on exit so an enclosing loop can re-enter it
         if (isLoop0) loop0Count <= loop0Done ? `TSS_RST_WORD : loop0Count + 16'h0001;
         if (isLoop1) loop1Count <= loop1Done ? `TSS_RST_WORD : loop1Count + 16'h0001;
      end
   end

   // ==========================================================
   // Step pointer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stepPointer <= `TSS_RST_PTR;
      end else if (wrPointer) begin
         stepPointer <= regWrData[4:0];
      end else if (running & (state == TSS_NEXT)) begin
         stepPointer <= jumpTaken ? jumpTarget : stepPointer + 5'h01;
      end
   end

   // ==========================================================
   // Step engine
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state      <= TSS_IDLE;
         waitKind   <= TSS_W_RISE;
         waitSelect <= 4'h0;
         stepByte   <= 8'h00;
         jumpTaken  <= 1'b0;
         jumpTarget <= `TSS_RST_PTR;
         delayOn    <= `TSS_RST_DELAY_ON;
         timerCount <= `TSS_RST_WORD;
         delayCount <= `TSS_RST_WORD;
      end else if (~running) begin
         state <= TSS_IDLE;
      end else begin
         case (state)
            TSS_IDLE: begin
               state <= TSS_FETCH;
            end
            TSS_FETCH: begin
               // Odd step in the high byte of its pair
               stepByte <= stepPointer[0] ? stepQueue[stepPointer[3:1]][15:8]
                                          : stepQueue[stepPointer[3:1]][7:0];
               state    <= TSS_EXEC;
            end
            TSS_EXEC: begin
               jumpTarget <= fiveBit;
               jumpTaken  <= isJump | (isLoop0 & ~loop0Done) | (isLoop1 & ~loop1Done);
               timerCount <= `TSS_RST_WORD;
               delayCount <= `TSS_RST_WORD;
               waitSelect <= option;
               if (isControl & (option == `TSS_OPT_DELAY_OFF)) delayOn <= 1'b0;
               if (isControl & (option == `TSS_OPT_DELAY_ON))  delayOn <= 1'b1;
               if (opcode == `TSS_OP_WAIT_FALL)    waitKind <= TSS_W_FALL;
               else if (opcode == `TSS_OP_WAIT_RISE) waitKind <= TSS_W_RISE;
               else if (option == `TSS_OPT_TIMER0) waitKind <= TSS_W_TIMER0;
               else if (option == `TSS_OPT_TIMER1) waitKind <= TSS_W_TIMER1;
               else                                waitKind <= TSS_W_SWTRIG;
               // Reserved codes fall through to the delay as a plain step
               state <= waitsNow ? TSS_WAIT : TSS_DELAY;
            end
            TSS_WAIT: begin
               timerCount <= timerCount + 16'h0001;
               if (waitMet) state <= TSS_DELAY;
            end
            TSS_DELAY: begin
               delayCount <= delayCount + 16'h0001;
               if (delayDone) state <= TSS_NEXT;
            end
            TSS_NEXT: begin
               state <= TSS_FETCH;
            end
            default: begin
               state <= TSS_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== verification/tss_sequencer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.svh"

// ==========================================================
// Port checker
module tss_sequencer_sva (
   input wire logic                   core_clk,
   input wire logic                   reset,
   input wire logic [`TSS_ADDR_W-1:0] regAddr,
   input wire logic [15:0]            regWrData,
   input wire logic                   regWrite,
   input wire logic                   regRead,
   input wire logic [15:0]            regRdData,
   input wire logic [15:0]            triggerIn,
   input wire logic [31:0]            triggerOut,
   input wire logic [15:0]            irqOut,
   input wire logic [15:0]            adcChannelSelect
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_reset_clears_outs: assert property (disable iff (1'b0) reset |=> regRdData == 16'h0 && triggerOut == 32'h0
      && irqOut == 16'h0 && adcChannelSelect == 16'h0) else $error("outputs not cleared by reset");
   a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 16'h0) else $error("read data outside slot");
   a_ptr_upper_zero: assert property ($past(regRead) && $past(regAddr) == `TSS_OFF_POINTER
      |-> regRdData[15:5] == 11'h0) else $error("pointer upper bits set");
   a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) == 5'h0e |-> regRdData == 16'h0)
      else $error("unmapped read not zero");
   a_trig_step_gap: assert property (triggerOut != 32'h0 |=> (triggerOut == 32'h0) [*3])
      else $error("trigger steps closer than step period");
   a_trig_single: assert property (triggerOut[31:16] != 16'h0 |-> $onehot(triggerOut))
      else $error("more than one upper trigger");
   a_irq_single: assert property (irqOut != 16'h0 |-> $onehot(irqOut) ##1 irqOut == 16'h0)
      else $error("irq not a single pulse");
   a_adc_own_step: assert property ($changed(adcChannelSelect) |-> triggerOut == 32'h0 && irqOut == 16'h0)
      else $error("channel select changed with other action");

   c_trig: cover property (triggerOut[17]);
   c_irq: cover property (irqOut != 16'h0);
   c_bcast: cover property (triggerOut == 32'h5);
endmodule

bind tss_sequencer tss_sequencer_sva tss_sequencer_sva_i (.core_clk, .reset, .regAddr, .regWrData, .regWrite,
   .regRead, .regRdData, .triggerIn, .triggerOut, .irqOut, .adcChannelSelect);
`default_nettype wire

// ==== verification/tss_peripheral_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far-side peripherals: one trigger source, pulse counters
module tss_peripheral_model (
   input  wire logic        core_clk,
   input  wire logic        edgeReq,
   input  wire logic [31:0] triggerOut,
   input  wire logic [15:0] irqOut,
   output logic      [15:0] triggerIn,
   output logic      [15:0] trig3Count,
   output logic      [15:0] trig17Count,
   output logic      [15:0] bcastCount,
   output logic      [15:0] irqCount,
   output logic      [15:0] strayCount
);
   initial begin
      triggerIn = 16'h0;
      {trig3Count, trig17Count, bcastCount, irqCount, strayCount} = '0;
   end
   // Source 2 toggles on each request: first one rises, next one falls
   always @(posedge core_clk) if (edgeReq) triggerIn[2] <= ~triggerIn[2];
   always @(posedge core_clk) begin
      if (triggerOut == 32'h8) trig3Count <= trig3Count + 16'h1;
      else if (triggerOut == 32'h20000) trig17Count <= trig17Count + 16'h1;
      else if (triggerOut == 32'h5) bcastCount <= bcastCount + 16'h1;
      else if (triggerOut != 32'h0) strayCount <= strayCount + 16'h1;
      if (irqOut == 16'h2) irqCount <= irqCount + 16'h1;
      else if (irqOut != 16'h0) strayCount <= strayCount + 16'h1;
   end
endmodule
`default_nettype wire

// ==== verification/trigger_step_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module trigger_step_sequencer_tb;
   logic core_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, edgeReq = 1'b0;
   logic [4:0]  regAddr = 5'h0;
   logic [15:0] regWrData = 16'h0, regRdData, triggerIn, irqOut, adcChannelSelect, got;
   logic [15:0] trig3Count, trig17Count, bcastCount, irqCount, strayCount;
   logic [31:0] triggerOut;
   int miscompares = 0, samples_checked = 0;
   // Address, write data, expected read-back
   localparam logic [36:0] ROWS [17] = '{
      {5'h01, 16'h0000, 16'h0000}, {5'h04, 16'h0002, 16'h0002}, {5'h05, 16'hffff, 16'hffff},
      {5'h06, 16'h1234, 16'h1234}, {5'h07, 16'h0001, 16'h0001}, {5'h08, 16'h00ff, 16'h00ff},
      {5'h09, 16'hffff, 16'h001f}, {5'h09, 16'h0000, 16'h0000}, {5'h0a, 16'h0005, 16'h0005},
      {5'h0b, 16'hffff, 16'h0000}, {5'h0e, 16'h5555, 16'h0000}, {5'h10, 16'h1d83, 16'h1d83},
      {5'h11, 16'h0e15, 16'h0e15}, {5'h12, 16'h4225, 16'h4225}, {5'h13, 16'h9171, 16'h9171},
      {5'h14, 16'h0fc7, 16'h0fc7}, {5'h15, 16'h00aa, 16'h00aa}};

   always #10 core_clk = ~core_clk;

   tss_sequencer tss_sequencer_i (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .triggerIn(triggerIn),
      .triggerOut(triggerOut), .irqOut(irqOut), .adcChannelSelect(adcChannelSelect));
   tss_peripheral_model tss_peripheral_model_i (.core_clk(core_clk), .edgeReq(edgeReq), .triggerOut(triggerOut),
      .irqOut(irqOut), .triggerIn(triggerIn), .trig3Count(trig3Count), .trig17Count(trig17Count),
      .bcastCount(bcastCount), .irqCount(irqCount), .strayCount(strayCount));

   // ==========================================================
   // Bus and compare tasks
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 got = regRdData;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
      rd(a);
      chk(got, e);
   endtask
   task automatic results();
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      rdchk(5'h00, 16'h0008);
      for (int i = 4; i < 10; i++) rdchk(5'(i), 16'h0000);
      foreach (ROWS[i]) begin
         wr(ROWS[i][36:32], ROWS[i][31:16]);
         rdchk(ROWS[i][36:32], ROWS[i][15:0]);
      end
      $display("register table done");
      wr(5'h00, 16'h0003);
      repeat (60) @(posedge core_clk);
      rdchk(5'h09, 16'h0005);
      chk(irqCount, 16'h0);
      chk(adcChannelSelect, 16'h1225);
      wr(5'h06, 16'h9999);
      rdchk(5'h06, 16'h1234);
      edgeReq <= 1'b1;
      @(posedge core_clk);
      edgeReq <= 1'b0;
      for (int n = 0; bcastCount !== 16'h1; n++) begin
         if (n == 300) begin
            miscompares++;
            $display("[FAIL] %0t sequence did not reach broadcast", $time);
            results();
         end
         @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
      rdchk(5'h09, 16'h000a);
      rdchk(5'h0b, 16'h1225);
      chk(trig3Count, 16'h1);
      chk(irqCount, 16'h1);
      chk(trig17Count, 16'h3);
      chk(strayCount, 16'h0);
      $display("sequence run done");
      // Second program: reserved step 11, counter-1 loop 12-13, fall wait 14, self jump 15
      wr(5'h00, 16'h0000);
      wr(5'h09, 16'h000b);
      wr(5'h05, 16'h0001);
      wr(5'h16, 16'hec0d);
      wr(5'h17, 16'haf52);
      wr(5'h00, 16'h0003);
      repeat (40) @(posedge core_clk);
      rdchk(5'h09, 16'h000e);
      chk(adcChannelSelect, 16'h0001);
      edgeReq <= 1'b1;
      @(posedge core_clk);
      edgeReq <= 1'b0;
      repeat (20) @(posedge core_clk);
      rdchk(5'h09, 16'h000f);
      rdchk(5'h0d, 16'h0000);
      chk(strayCount, 16'h0);
      chk(irqCount, 16'h1);
      $display("second program done");
      wr(5'h00, 16'h0000);
      wr(5'h09, 16'h0011);
      rdchk(5'h09, 16'h0011);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      rdchk(5'h10, 16'h1d83);
      rdchk(5'h15, 16'h00aa);
      rdchk(5'h09, 16'h0000);
      chk(adcChannelSelect, 16'h0000);
      $display("reset test done");
      results();
   end
endmodule
`default_nettype wire
